// >>> logic/sser_regs.svh
// Register map, field positions, reset values of the status event block.
// Assumes a 32-bit AXI4-Lite slave, one aligned word per register.
// Operation
// - Rising filter bit 10 latches constant current.
// - Enabled operation events OR into summary.
// - Request mask 128 lets operation summary request.
// - Operation event read returns bits, then clears.
// - Rising filters all ones at reset, preset.
// - Constant voltage at bit 8; 1280 covers both.
// - Overcurrent bit 1, overtemperature bit 4; 18.
// - Mask 136 requests on either summary.
// - Falling filter bit 10 latches leaving current.
// - Pending request sets status byte bit 6.
// - Request drives line; poll clears only bit.
// - Master summary: live OR of enabled bits.
// - Event register read clears; summary drops.
`ifndef SSER_REGS_SVH
`define SSER_REGS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SSER_OP_COND 8'h00
`define SSER_OP_RISE 8'h04
`define SSER_OP_FALL 8'h08
`define SSER_OP_EVENT 8'h0C
`define SSER_OP_ENAB 8'h10
`define SSER_QS_COND 8'h14
`define SSER_QS_RISE 8'h18
`define SSER_QS_FALL 8'h1C
`define SSER_QS_EVENT 8'h20
`define SSER_QS_ENAB 8'h24
`define SSER_SREQ_ENAB 8'h28
`define SSER_STB_QUERY 8'h2C
`define SSER_STB_POLL 8'h30
`define SSER_CTRL 8'h34
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SSER_BIT_VOLT 8
`define SSER_BIT_CURR 10
`define SSER_BIT_OVERCUR 1
`define SSER_BIT_OVERTEMP 4
`define SSER_STB_QS_SUM 3
`define SSER_STB_RQS 6
`define SSER_STB_OP_SUM 7
`define SSER_CTRL_PRESET 0
`define SSER_CTRL_CLEAR 1
`define SSER_RISE_RESET 16'hFFFF
`define SSER_FALL_RESET 16'h0000
`define SSER_ENAB_RESET 16'h0000
`endif

// >>> logic/sser_pkg.sv
// Types of the status event block.
// Assumes sser_regs.svh carries the numbers.
`default_nettype none
package sser_pkg;
  typedef logic [15:0] sser_word_t;
  typedef logic [7:0] sser_byte_t;
  typedef enum logic [1:0] {
    SSER_RD_IDLE = 2'b00,
    SSER_RD_RESP = 2'b01
  } sser_rd_t;
  typedef enum logic [1:0] {
    SSER_WR_IDLE = 2'b00,
    SSER_WR_RESP = 2'b01
  } sser_wr_t;
endpackage
`default_nettype wire

// >>> logic/sser_status.sv
// Status event block: two groups, transition filters, sticky events,
// status byte, service request line, AXI4-Lite register slave.
// Assumes condition flags come from another clock domain or pins.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "sser_regs.svh"
module sser_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic constant_voltage_flag,
  input wire logic constant_current_flag,
  input wire logic overcurrent_flag,
  input wire logic overtemperature_flag,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic service_request,
  output logic [7:0] status_byte
);
  import sser_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    sser_word_t op_prev;
    sser_word_t qs_prev;
    sser_word_t op_rise;
    sser_word_t op_fall;
    sser_word_t op_event;
    sser_word_t op_enab;
    sser_word_t qs_rise;
    sser_word_t qs_fall;
    sser_word_t qs_event;
    sser_word_t qs_enab;
    sser_byte_t sreq_enab;
    logic rqs;
    logic mss_prev;
    sser_byte_t stb;
    logic srq;
    sser_wr_t wr;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    sser_rd_t rd;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // Handshake outputs kept as flops of their own
    logic awrdy;
    logic wrdy;
    logic bvld;
    logic arrdy;
    logic rvld;
  } sser_state_t;

  sser_state_t st;
  sser_state_t next_st;
  sser_word_t op_cond;
  sser_word_t qs_cond;
  sser_word_t op_new;
  sser_word_t qs_new;
  logic operation_summary;
  logic questionable_summary;
  sser_byte_t stb_live;
  logic mss;
  logic rd_take;
  logic wr_do;
  logic [7:0] wa;
  logic [31:0] wv;

  // Live condition words from the synchronised flags
  always_comb begin
    op_cond = '0;
    qs_cond = '0;
    op_cond[`SSER_BIT_VOLT] = st.sync2[0];
    op_cond[`SSER_BIT_CURR] = st.sync2[1];
    qs_cond[`SSER_BIT_OVERCUR] = st.sync2[2];
    qs_cond[`SSER_BIT_OVERTEMP] = st.sync2[3];
  end

  // Edge detection through the filters, per bit
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_edge
      assign op_new[gi] = (st.op_rise[gi] & op_cond[gi] & ~st.op_prev[gi])
        | (st.op_fall[gi] & ~op_cond[gi] & st.op_prev[gi]);
      assign qs_new[gi] = (st.qs_rise[gi] & qs_cond[gi] & ~st.qs_prev[gi])
        | (st.qs_fall[gi] & ~qs_cond[gi] & st.qs_prev[gi]);
    end
  endgenerate

  // Summaries and status byte
  assign operation_summary = |(st.op_event & st.op_enab);
  assign questionable_summary = |(st.qs_event & st.qs_enab);
  always_comb begin
    stb_live = '0;
    stb_live[`SSER_STB_OP_SUM] = operation_summary;
    stb_live[`SSER_STB_QS_SUM] = questionable_summary;
  end
  assign mss = |(stb_live & st.sreq_enab);

  assign rd_take = s_axi_arvalid && st.rd == SSER_RD_IDLE;
  assign wr_do = st.wr == SSER_WR_IDLE && st.aw_got && st.w_got;
  assign wa = st.awaddr;
  assign wv = st.wdata;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.sync1 = {overtemperature_flag, overcurrent_flag, constant_current_flag,
      constant_voltage_flag};
    next_st.sync2 = st.sync1;
    next_st.op_prev = op_cond;
    next_st.qs_prev = qs_cond;
    // Sticky events; new edges always OR in after any clear
    next_st.op_event = st.op_event | op_new;
    next_st.qs_event = st.qs_event | qs_new;
    // Request bit latches on a rising master summary
    if (mss && !st.mss_prev) begin
      next_st.rqs = 1'b1;
    end
    next_st.mss_prev = mss;

    // Write channel
    if (s_axi_awvalid && !st.aw_got && st.wr == SSER_WR_IDLE) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_got && st.wr == SSER_WR_IDLE) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.wr == SSER_WR_RESP && s_axi_bready) begin
      next_st.wr = SSER_WR_IDLE;
    end
    if (wr_do) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.wr = SSER_WR_RESP;
      next_st.bresp = 2'b00;
      unique case (wa)
        `SSER_OP_RISE: next_st.op_rise = wv[15:0];
        `SSER_OP_FALL: next_st.op_fall = wv[15:0];
        `SSER_OP_ENAB: next_st.op_enab = wv[15:0];
        `SSER_QS_RISE: next_st.qs_rise = wv[15:0];
        `SSER_QS_FALL: next_st.qs_fall = wv[15:0];
        `SSER_QS_ENAB: next_st.qs_enab = wv[15:0];
        `SSER_SREQ_ENAB: next_st.sreq_enab = wv[7:0];
        `SSER_CTRL: begin
          if (wv[`SSER_CTRL_PRESET]) begin
            next_st.op_rise = `SSER_RISE_RESET;
            next_st.qs_rise = `SSER_RISE_RESET;
            next_st.op_fall = `SSER_FALL_RESET;
            next_st.qs_fall = `SSER_FALL_RESET;
            next_st.op_enab = `SSER_ENAB_RESET;
            next_st.qs_enab = `SSER_ENAB_RESET;
          end
          // Clear keeps coincident edges, and a new request rise wins
          if (wv[`SSER_CTRL_CLEAR]) begin
            next_st.op_event = op_new;
            next_st.qs_event = qs_new;
            next_st.rqs = mss && !st.mss_prev;
          end
        end
        default: next_st.bresp = 2'b10;
      endcase
    end

    // Read channel; event reads clear but keep coincident edges
    if (st.rd == SSER_RD_RESP && s_axi_rready) begin
      next_st.rd = SSER_RD_IDLE;
    end
    if (rd_take) begin
      next_st.rd = SSER_RD_RESP;
      next_st.rresp = 2'b00;
      next_st.rdata = '0;
      unique case (s_axi_araddr)
        `SSER_OP_COND: next_st.rdata[15:0] = op_cond;
        `SSER_OP_RISE: next_st.rdata[15:0] = st.op_rise;
        `SSER_OP_FALL: next_st.rdata[15:0] = st.op_fall;
        `SSER_OP_EVENT: begin
          next_st.rdata[15:0] = st.op_event;
          next_st.op_event = op_new;
        end
        `SSER_OP_ENAB: next_st.rdata[15:0] = st.op_enab;
        `SSER_QS_COND: next_st.rdata[15:0] = qs_cond;
        `SSER_QS_RISE: next_st.rdata[15:0] = st.qs_rise;
        `SSER_QS_FALL: next_st.rdata[15:0] = st.qs_fall;
        `SSER_QS_EVENT: begin
          next_st.rdata[15:0] = st.qs_event;
          next_st.qs_event = qs_new;
        end
        `SSER_QS_ENAB: next_st.rdata[15:0] = st.qs_enab;
        `SSER_SREQ_ENAB: next_st.rdata[7:0] = st.sreq_enab;
        `SSER_STB_QUERY: begin
          next_st.rdata[7:0] = stb_live;
          next_st.rdata[`SSER_STB_RQS] = mss;
        end
        `SSER_STB_POLL: begin
          next_st.rdata[7:0] = stb_live;
          next_st.rdata[`SSER_STB_RQS] = st.rqs;
          next_st.rqs = mss && !st.mss_prev;
        end
        `SSER_CTRL: next_st.rdata = '0;
        default: next_st.rresp = 2'b10;
      endcase
    end

    // Registered outputs
    next_st.stb = stb_live;
    next_st.stb[`SSER_STB_RQS] = next_st.rqs;
    next_st.srq = next_st.rqs;
    // Handshake flags registered from the next channel state
    next_st.awrdy = !next_st.aw_got && next_st.wr == SSER_WR_IDLE;
    next_st.wrdy = !next_st.w_got && next_st.wr == SSER_WR_IDLE;
    next_st.bvld = next_st.wr == SSER_WR_RESP;
    next_st.arrdy = next_st.rd == SSER_RD_IDLE;
    next_st.rvld = next_st.rd == SSER_RD_RESP;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.op_rise <= `SSER_RISE_RESET;
      st.qs_rise <= `SSER_RISE_RESET;
      st.wr <= SSER_WR_IDLE;
      st.rd <= SSER_RD_IDLE;
      // Idle channels accept right after reset
      st.awrdy <= 1'b1;
      st.wrdy <= 1'b1;
      st.arrdy <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Bus and pin outputs straight from flops
  assign s_axi_awready = st.awrdy;
  assign s_axi_wready = st.wrdy;
  assign s_axi_bvalid = st.bvld;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arrdy;
  assign s_axi_rvalid = st.rvld;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign service_request = st.srq;
  assign status_byte = st.stb;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_cc_rise_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st.op_rise[10] && op_cond[10] && !st.op_prev[10]
    |=> st.op_event[10]) else $error("rising current edge not latched");
  chk_cc_fall_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st.op_fall[10] && !op_cond[10] && st.op_prev[10]
    |=> st.op_event[10]) else $error("falling current edge not latched");
  chk_operation_summary_sum_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> status_byte[7] == $past(operation_summary))
    else $error("operation summary wrong");
  chk_mss_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    mss == ((operation_summary && st.sreq_enab[7])
      || (questionable_summary && st.sreq_enab[3])))
    else $error("master summary mask wrong");
  chk_rqs_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && mss && !st.mss_prev |=> service_request && status_byte[6])
    else $error("request bit not set");
  chk_poll_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && rd_take && s_axi_araddr == `SSER_STB_POLL && !(mss && !st.mss_prev)
    |=> !service_request) else $error("poll did not clear request");
  chk_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && rd_take && s_axi_araddr == `SSER_OP_EVENT && op_new == 16'h0000
    |=> st.op_event == 16'h0000) else $error("event read did not clear");
  chk_edge_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && rd_take && s_axi_araddr == `SSER_OP_EVENT && op_new[10]
    |=> st.op_event[10]) else $error("coincident edge lost");
  chk_sticky_event: assert property (@(posedge aclk) disable iff (!aresetn)
    st.op_event[8] && !(clk_en && rd_take) && !wr_do |=> st.op_event[8])
    else $error("event bit dropped without read");
  chk_cv_rise_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st.op_rise[8] && op_cond[8] && !st.op_prev[8]
    |=> st.op_event[8]) else $error("rising voltage edge not latched");
  chk_qs_rise_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st.qs_rise[4] && qs_cond[4] && !st.qs_prev[4]
    |=> st.qs_event[4]) else $error("rising overtemperature edge not latched");
  chk_preset_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wr_do && wa == `SSER_CTRL && wv[`SSER_CTRL_PRESET]
    |=> st.op_rise == 16'hFFFF && st.qs_rise == 16'hFFFF)
    else $error("preset did not set rising filters");
  chk_query_live: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && rd_take && s_axi_araddr == `SSER_STB_QUERY
    |=> s_axi_rdata[6] == $past(mss)) else $error("query bit 6 not live summary");
  chk_poll_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && rd_take && s_axi_araddr == `SSER_STB_POLL
    |=> status_byte[7] == $past(operation_summary)
      && status_byte[3] == $past(questionable_summary))
    else $error("poll disturbed summary bits");
endmodule
`default_nettype wire

// >>> test/sser_ctl_model.sv
// Remote controller model: AXI4-Lite master tasks for the status block.
// Assumes one clock; the bench calls wr and rd in this instance.
`timescale 1ns/1ns
`default_nettype none
module sser_ctl_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // Response code of the last finished write
  logic [1:0] last_bresp;
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  // Write: both channels offered at once, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a; // Released lines show no stale value
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        last_bresp = bresp; // Taken at the answering edge
        break;
      end
    end
    bready <= 1'b0;
  endtask
  // Read: data and response taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> test/sser_status_tb.sv
// Self-checking bench of the status event block.
// Assumes the controller model drives the register bus.
`timescale 1ns/1ns
`default_nettype none
`include "sser_regs.svh"
module sser_status_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic flag_volt = 1'b0, flag_curr = 1'b0, flag_ovcur = 1'b0, flag_ovtemp = 1'b0;
  logic [7:0] awaddr, araddr, status_byte;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, service_request;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  int fails = 0, cmp_count = 0;
  // ----------------------------------------------------------------
  // Clock, design and controller
  // ----------------------------------------------------------------
  always #25 aclk = ~aclk;
  sser_status i_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .constant_voltage_flag(flag_volt), .constant_current_flag(flag_curr),
    .overcurrent_flag(flag_ovcur), .overtemperature_flag(flag_ovtemp),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .service_request(service_request),
    .status_byte(status_byte));
  sser_ctl_model i_ctl (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bresp(bresp), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  // ----------------------------------------------------------------
  // Compare and helper tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rx(input logic [7:0] a, input logic [31:0] exp);
    i_ctl.rd(a, d, r);
    chk(d, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog against a hung bus
  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    wt(10);
    aresetn <= 1'b1;
    rx(`SSER_OP_RISE, 32'h0000FFFF);
    rx(`SSER_QS_RISE, 32'h0000FFFF);
    i_ctl.wr(`SSER_OP_RISE, 32'd1024);
    i_ctl.wr(`SSER_OP_ENAB, 32'd1024);
    i_ctl.wr(`SSER_SREQ_ENAB, 32'd128);
    flag_curr <= 1'b1;
    wt(8);
    chk({24'h0, status_byte}, 32'hC0);
    chk({31'h0, service_request}, 32'h1);
    rx(`SSER_STB_QUERY, 32'hC0);
    rx(`SSER_OP_EVENT, 32'h400);
    wt(2);
    chk({24'h0, status_byte}, 32'h40);
    rx(`SSER_STB_POLL, 32'h40);
    wt(2);
    chk({23'h0, service_request, status_byte}, 32'h0);
    // Leaving constant current is caught by the falling filter
    i_ctl.wr(`SSER_OP_FALL, 32'd1024);
    flag_curr <= 1'b0;
    wt(8);
    chk({31'h0, service_request}, 32'h1);
    rx(`SSER_OP_EVENT, 32'h400);
    rx(`SSER_STB_POLL, 32'h40);
    // Constant voltage event stays latched after the flag drops
    i_ctl.wr(`SSER_OP_FALL, 32'd0);
    i_ctl.wr(`SSER_OP_RISE, 32'd1280);
    i_ctl.wr(`SSER_OP_ENAB, 32'd1280);
    flag_volt <= 1'b1;
    wt(8);
    flag_volt <= 1'b0;
    wt(8);
    rx(`SSER_OP_EVENT, 32'h100);
    rx(`SSER_STB_POLL, 32'h40);
    // Questionable group with both summaries enabled
    i_ctl.wr(`SSER_QS_RISE, 32'd18);
    i_ctl.wr(`SSER_QS_ENAB, 32'd18);
    i_ctl.wr(`SSER_SREQ_ENAB, 32'd136);
    flag_ovcur <= 1'b1;
    flag_ovtemp <= 1'b1;
    wt(8);
    chk({23'h0, service_request, status_byte}, 32'h148);
    // Poll clears only the request bit, summary bit 3 stays
    rx(`SSER_STB_POLL, 32'h48);
    wt(2);
    chk({23'h0, service_request, status_byte}, 32'h008);
    rx(`SSER_QS_EVENT, 32'h12);
    wt(2);
    chk({23'h0, service_request, status_byte}, 32'h0);
    // Preset restores the rising filters
    i_ctl.wr(`SSER_CTRL, 32'h1);
    rx(`SSER_OP_RISE, 32'h0000FFFF);
    rx(`SSER_QS_RISE, 32'h0000FFFF);
    // Edge seen in the very cycle the event read is taken survives the clear
    flag_curr <= 1'b1;
    wt(1);
    rx(`SSER_OP_EVENT, 32'h0);
    rx(`SSER_OP_EVENT, 32'h400);
    // Control clear empties an event that no read has fetched
    flag_volt <= 1'b1;
    wt(8);
    i_ctl.wr(`SSER_CTRL, 32'h2);
    rx(`SSER_OP_EVENT, 32'h0);
    // Unmapped offsets answer with a slave error
    i_ctl.rd(8'hFC, d, r);
    chk({30'h0, r}, 32'h2);
    i_ctl.wr(8'hFC, 32'h0);
    chk({30'h0, i_ctl.last_bresp}, 32'h2);
    summarize();
  end
endmodule
`default_nettype wire
